/* File: core/drsel_pkg.sv */
// Package of the reference source selector: constants, enumerations, carriers.
// Assumes a single 100 MHz clock and a register bus word of 32 bits.
package drsel_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned SAMPLE_US   = 2000;
  localparam int unsigned SAMPLE_CYC  = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOLD_MS     = 3000;
  localparam int unsigned IDLE_MS     = 240_000;
  localparam int unsigned BLINK_MS    = 500;
  localparam int unsigned HOLD_TICKS  = HOLD_MS * 1000 / SAMPLE_US;
  localparam int unsigned IDLE_TICKS  = IDLE_MS * 1000 / SAMPLE_US;
  localparam int unsigned BLINK_TICKS = BLINK_MS * 1000 / SAMPLE_US;
  localparam int unsigned TICK_W      = 18;
  localparam int unsigned HOLD_W      = 11;
  localparam int unsigned IDLE_W      = 17;
  localparam int unsigned BLINK_W     = 8;
  localparam int unsigned PAR_COUNT   = 80;
  localparam logic [6:0]  PAR_SPEED_LIMIT = 7'h02;
  localparam logic [6:0]  PAR_CONFIG      = 7'h05;
  localparam logic [6:0]  PAR_DIGITAL_REF = 7'h12;
  localparam logic [6:0]  PAR_KEYPAD_REF  = 7'h14;
  localparam logic [6:0]  PAR_PRESET_BASE = 7'h15;
  localparam logic [6:0]  SEL_PARAM_RST   = 7'h01;
  localparam logic [15:0] PARAM_RST       = 16'h0000;
  localparam logic [31:0] PARAM_OFF       = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFF      = 32'h0000_0200;

  typedef enum logic [3:0] {
    CFG_VOLT_PR, CFG_CURR_PR, CFG_FOUR_PR, CFG_EIGHT_PR, CFG_MOTOR_POT, CFG_SPEED_TORQUE,
    CFG_PID, CFG_PUMP, CFG_VOLT_CURR_THERM, CFG_HOIST, CFG_KEYPAD, CFG_AUTO_MANUAL
  } drsel_cfg_e;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_AIN1_VOLT, SRC_AIN1_CURR, SRC_AIN2, SRC_PRESET, SRC_DIGITAL, SRC_KEYPAD
  } drsel_src_e;
  typedef enum logic [1:0] {DM_STATUS, DM_PARAM, DM_EDIT} drsel_dmode_e;

  typedef struct packed {
    logic digital_input_two;
    logic digital_input_three;
    logic digital_input_four;
    logic analog_input_one;
    logic analog_input_two;
    logic secure_enable_input;
    logic sw_auto;
    logic sw_manual;
    logic key_mode;
    logic key_up;
    logic key_down;
    logic key_rev;
    logic key_stop;
    logic key_fwd;
  } drsel_pins_s;
  typedef struct packed {
    drsel_src_e  src;
    logic [3:0]  preset_num;
    logic        torque_mode;
    logic        pid_en;
    logic [15:0] ref_value;
    logic [15:0] speed_limit;
    logic        run_fwd;
    logic        run_rev;
    logic        drive_en;
  } drsel_sel_s;
  typedef struct packed {
    logic [3:0][6:0] seg;
    logic            sign_led;
    logic            param_mode;
  } drsel_disp_s;
  typedef struct packed {
    drsel_pins_s                  sync1;
    drsel_pins_s                  sync2;
    drsel_pins_s                  samp;
    drsel_pins_s                  prev;
    logic [TICK_W-1:0]            tick_cnt;
    logic                         tick_d;
    logic [PAR_COUNT-1:0][15:0]   params;
    drsel_dmode_e                 dmode;
    logic [6:0]                   sel_param;
    logic [HOLD_W-1:0]            hold_cnt;
    logic [IDLE_W-1:0]            idle_cnt;
    logic [BLINK_W-1:0]           blink_cnt;
    logic                         phase;
    logic                         kp_fwd;
    logic                         kp_rev;
    logic                         trip;
    logic                         wr_pend;
    logic [6:0]                   wr_idx;
    logic [31:0]                  rdata;
    drsel_sel_s                   sel;
    drsel_disp_s                  disp;
  } drsel_state_s;
endpackage : drsel_pkg

/* File: core/drsel_selector.sv */
// Reference source selector with operator panel and AHB-Lite parameter access.
// Assumes asynchronous terminal and key pins, one clock, a single AHB-Lite master.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module drsel_selector #(
  parameter int unsigned TICK_CYCLES = drsel_pkg::SAMPLE_CYC,
  parameter int unsigned HOLD_TICKS  = drsel_pkg::HOLD_TICKS,
  parameter int unsigned IDLE_TICKS  = drsel_pkg::IDLE_TICKS,
  parameter int unsigned BLINK_TICKS = drsel_pkg::BLINK_TICKS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  drsel_pkg::drsel_pins_s    pins_in,
  output drsel_pkg::drsel_sel_s     sel_out,
  output drsel_pkg::drsel_disp_s    disp_out,
  output logic                      trip_reset
);

  drsel_pkg::drsel_state_s s_reg;
  drsel_pkg::drsel_state_s s_next;
  drsel_pkg::drsel_cfg_e   cfg_w;
  logic                    tick_w;

  // Segment pattern a..g, bit 0 is segment a, active high.
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0:    seg7 = 7'h3F;
      4'h1:    seg7 = 7'h06;
      4'h2:    seg7 = 7'h5B;
      4'h3:    seg7 = 7'h4F;
      4'h4:    seg7 = 7'h66;
      4'h5:    seg7 = 7'h6D;
      4'h6:    seg7 = 7'h7D;
      4'h7:    seg7 = 7'h07;
      4'h8:    seg7 = 7'h7F;
      4'h9:    seg7 = 7'h6F;
      4'hA:    seg7 = 7'h77;
      4'hB:    seg7 = 7'h7C;
      4'hC:    seg7 = 7'h39;
      4'hD:    seg7 = 7'h5E;
      4'hE:    seg7 = 7'h79;
      default: seg7 = 7'h71;
    endcase
  endfunction : seg7

  // A word address inside the parameter window; parameter n sits at word n-1.
  function automatic logic param_hit(input logic [31:0] a);
    param_hit = (a - drsel_pkg::PARAM_OFF) < 32'(4 * drsel_pkg::PAR_COUNT) && a[1:0] == 2'h0;
  endfunction : param_hit

  assign cfg_w     = drsel_pkg::drsel_cfg_e'(s_reg.params[drsel_pkg::PAR_CONFIG - 7'h01][3:0]);
  assign tick_w    = s_reg.tick_cnt == drsel_pkg::TICK_W'(TICK_CYCLES - 1);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;
  assign sel_out   = s_reg.sel;
  assign disp_out  = s_reg.disp;
  assign trip_reset = s_reg.trip;

  // Whole next state: sampling, selection, panel, bus. Outputs other than the tied hreadyout and hresp leave from flops.
  always_comb begin
    drsel_pkg::drsel_pins_s press;
    drsel_pkg::drsel_sel_s  nsel;
    logic                   term_run;
    logic                   kp_run;
    logic [2:0]             code;
    logic [6:0]             pidx;
    logic [15:0]            val;
    logic [15:0]            mag;
    logic [6:0]             tens;
    logic [6:0]             units;
    logic                   show_num;
    logic                   any_key;
    s_next   = s_reg;
    press    = '0;
    nsel     = '0;
    term_run = 1'b0;
    kp_run   = 1'b0;
    code     = 3'h0;
    pidx     = 7'h00;
    val      = 16'h0000;
    mag      = 16'h0000;
    tens     = 7'h00;
    units    = 7'h00;
    show_num = 1'b0;
    any_key  = 1'b0;
    s_next.trip = 1'b0;
    s_next.tick_d = tick_w;

    // Two-stage synchroniser, then the slow sampling register on the tick.
    s_next.sync1 = pins_in;
    s_next.sync2 = s_reg.sync1;
    s_next.tick_cnt = tick_w ? '0 : s_reg.tick_cnt + 1'b1;
    if (tick_w) begin
      s_next.samp = s_reg.sync2;
      s_next.prev = s_reg.samp;
    end

    // Edges are only judged in the cycle after a fresh sample.
    if (s_reg.tick_d) begin
      press = s_reg.samp & ~s_reg.prev;
    end
    any_key = press.key_mode | press.key_up | press.key_down | press.key_rev | press.key_stop | press.key_fwd;

    // Keypad run latch; stop also pulses the trip reset.
    if (press.key_stop) begin
      s_next.kp_fwd = 1'b0;
      s_next.kp_rev = 1'b0;
      s_next.trip   = 1'b1;
    end else if (press.key_fwd) begin
      s_next.kp_fwd = 1'b1;
      s_next.kp_rev = 1'b0;
    end else if (press.key_rev) begin
      s_next.kp_fwd = 1'b0;
      s_next.kp_rev = 1'b1;
    end

    // Source selection from the sampled terminals only.
    term_run = 1'b1;
    nsel.drive_en    = s_reg.samp.secure_enable_input;
    nsel.speed_limit = s_reg.params[drsel_pkg::PAR_SPEED_LIMIT - 7'h01];
    case (cfg_w)
      drsel_pkg::CFG_VOLT_PR, drsel_pkg::CFG_CURR_PR: begin
        code = {1'b0, s_reg.samp.analog_input_two, s_reg.samp.digital_input_four};
        if (code == 3'h0) begin
          nsel.src = (cfg_w == drsel_pkg::CFG_VOLT_PR) ? drsel_pkg::SRC_AIN1_VOLT
                                                       : drsel_pkg::SRC_AIN1_CURR;
        end else begin
          nsel.src        = drsel_pkg::SRC_PRESET;
          nsel.preset_num = {1'b0, code} + 4'h1;
        end
      end
      drsel_pkg::CFG_FOUR_PR: begin
        nsel.src        = drsel_pkg::SRC_PRESET;
        nsel.preset_num = {2'h0, s_reg.samp.analog_input_one, s_reg.samp.digital_input_four} + 4'h1;
      end
      drsel_pkg::CFG_EIGHT_PR: begin
        nsel.src        = drsel_pkg::SRC_PRESET;
        nsel.preset_num = {1'b0, s_reg.samp.analog_input_two, s_reg.samp.analog_input_one,
                           s_reg.samp.digital_input_four} + 4'h1;
      end
      drsel_pkg::CFG_SPEED_TORQUE: begin
        nsel.torque_mode = s_reg.samp.digital_input_four;
        nsel.src = s_reg.samp.digital_input_four ? drsel_pkg::SRC_AIN2 : drsel_pkg::SRC_AIN1_VOLT;
      end
      drsel_pkg::CFG_PUMP: begin
        nsel.src = s_reg.samp.digital_input_three ? drsel_pkg::SRC_DIGITAL : drsel_pkg::SRC_AIN1_VOLT;
        nsel.pid_en = s_reg.samp.digital_input_four;
      end
      drsel_pkg::CFG_VOLT_CURR_THERM: begin
        nsel.src = s_reg.samp.digital_input_four ? drsel_pkg::SRC_AIN1_CURR : drsel_pkg::SRC_AIN1_VOLT;
      end
      drsel_pkg::CFG_KEYPAD: begin
        nsel.src = drsel_pkg::SRC_KEYPAD;
        term_run = 1'b0;
        kp_run   = 1'b1;
      end
      drsel_pkg::CFG_AUTO_MANUAL: begin
        if (s_reg.samp.sw_auto) begin
          nsel.src = drsel_pkg::SRC_AIN1_VOLT;
        end else if (s_reg.samp.sw_manual) begin
          nsel.src = drsel_pkg::SRC_KEYPAD;
          term_run = 1'b0;
          kp_run   = 1'b1;
        end else begin
          nsel.src = drsel_pkg::SRC_NONE;
          term_run = 1'b0;
        end
      end
      default: begin
        // Modes whose internals live elsewhere fall back to the plain speed reference.
        nsel.src = drsel_pkg::SRC_AIN1_VOLT;
      end
    endcase

    // Run commands; secure enable gates both paths and never starts a run itself.
    if (term_run) begin
      nsel.run_fwd = nsel.drive_en & s_reg.samp.digital_input_two;
      nsel.run_rev = nsel.drive_en & s_reg.samp.digital_input_three & ~s_reg.samp.digital_input_two
                     & (cfg_w != drsel_pkg::CFG_PUMP);
    end
    if (kp_run) begin
      nsel.run_fwd = nsel.drive_en & s_reg.kp_fwd;
      nsel.run_rev = nsel.drive_en & s_reg.kp_rev;
    end

    // Reference word for the digital sources; analog ones are scaled downstream.
    case (nsel.src)
      drsel_pkg::SRC_PRESET: begin
        pidx = drsel_pkg::PAR_PRESET_BASE + {3'h0, nsel.preset_num} - 7'h02;
        nsel.ref_value = s_reg.params[pidx];
      end
      drsel_pkg::SRC_DIGITAL: nsel.ref_value = s_reg.params[drsel_pkg::PAR_DIGITAL_REF - 7'h01];
      drsel_pkg::SRC_KEYPAD:  nsel.ref_value = s_reg.params[drsel_pkg::PAR_KEYPAD_REF - 7'h01];
      default:                nsel.ref_value = 16'h0000;
    endcase
    s_next.sel = nsel;

    // Panel mode machine; the hold exit takes priority over presses, while a press cancels the idle exit.
    if (any_key) begin
      s_next.idle_cnt = '0;
    end else if (s_reg.tick_d && s_reg.dmode != drsel_pkg::DM_STATUS) begin
      s_next.idle_cnt = s_reg.idle_cnt + 1'b1;
    end
    if (s_reg.tick_d) begin
      s_next.hold_cnt = s_reg.samp.key_mode ? s_reg.hold_cnt + 1'b1 : '0;
    end
    case (s_reg.dmode)
      drsel_pkg::DM_STATUS: begin
        if (press.key_mode) begin
          s_next.dmode     = drsel_pkg::DM_PARAM;
          s_next.blink_cnt = '0;
          s_next.phase     = 1'b0;
        end
      end
      drsel_pkg::DM_PARAM, drsel_pkg::DM_EDIT: begin
        if (s_reg.tick_d && s_reg.samp.key_mode &&
            s_reg.hold_cnt == drsel_pkg::HOLD_W'(HOLD_TICKS - 1)) begin
          s_next.dmode = drsel_pkg::DM_STATUS;
        end else if (s_reg.tick_d && !any_key &&
                     s_reg.idle_cnt == drsel_pkg::IDLE_W'(IDLE_TICKS - 1)) begin
          s_next.dmode = drsel_pkg::DM_STATUS;
        end else if (press.key_mode) begin
          s_next.dmode = (s_reg.dmode == drsel_pkg::DM_PARAM) ? drsel_pkg::DM_EDIT : drsel_pkg::DM_PARAM;
        end else if (s_reg.dmode == drsel_pkg::DM_PARAM) begin
          if (press.key_up && s_reg.sel_param != 7'(drsel_pkg::PAR_COUNT)) begin
            s_next.sel_param = s_reg.sel_param + 7'h01;
          end else if (press.key_down && s_reg.sel_param != 7'h01) begin
            s_next.sel_param = s_reg.sel_param - 7'h01;
          end
        end else begin
          if (press.key_up) begin
            s_next.params[s_reg.sel_param - 7'h01] = s_reg.params[s_reg.sel_param - 7'h01] + 16'h0001;
          end else if (press.key_down) begin
            s_next.params[s_reg.sel_param - 7'h01] = s_reg.params[s_reg.sel_param - 7'h01] - 16'h0001;
          end
        end
      end
      default: s_next.dmode = drsel_pkg::DM_STATUS;
    endcase

    // Number and value alternate at the blink rate in parameter mode.
    if (s_reg.tick_d && s_reg.dmode == drsel_pkg::DM_PARAM) begin
      if (s_reg.blink_cnt == drsel_pkg::BLINK_W'(BLINK_TICKS - 1)) begin
        s_next.blink_cnt = '0;
        s_next.phase     = ~s_reg.phase;
      end else begin
        s_next.blink_cnt = s_reg.blink_cnt + 1'b1;
      end
    end

    // Display: status shows the reference word, parameter modes number or value.
    show_num = (s_reg.dmode == drsel_pkg::DM_PARAM) && !s_reg.phase;
    val = (s_reg.dmode == drsel_pkg::DM_STATUS) ? s_reg.sel.ref_value
                                                : s_reg.params[s_reg.sel_param - 7'h01];
    mag   = val[15] ? 16'h0000 - val : val;
    tens  = s_reg.sel_param / 7'h0A;
    units = s_reg.sel_param % 7'h0A;
    if (show_num) begin
      s_next.disp.seg = {7'h00, 7'h00, seg7(tens[3:0]), seg7(units[3:0])};
    end else begin
      s_next.disp.seg = {seg7(mag[15:12]), seg7(mag[11:8]), seg7(mag[7:4]), seg7(mag[3:0])};
    end
    s_next.disp.sign_led   = !show_num && val[15];
    s_next.disp.param_mode = s_reg.dmode != drsel_pkg::DM_STATUS;

    // AHB-Lite slave: zero wait, read data registered in the address phase.
    s_next.wr_pend = 1'b0;
    if (s_reg.wr_pend) begin
      s_next.params[s_reg.wr_idx] = hwdata[15:0];
    end
    if (hsel && hready && htrans[1]) begin
      s_next.wr_pend = hwrite && param_hit(haddr);
      s_next.wr_idx  = haddr[8:2];
      if (hwrite) begin
        s_next.rdata = 32'h0000_0000;
      end else if (param_hit(haddr)) begin
        // A read right behind a write to the same word sees the new data.
        s_next.rdata = (s_reg.wr_pend && s_reg.wr_idx == haddr[8:2]) ? {16'h0000, hwdata[15:0]}
                                                                     : {16'h0000, s_reg.params[haddr[8:2]]};
      end else if (haddr == drsel_pkg::STATUS_OFF) begin
        s_next.rdata = {16'h0000, s_reg.sel.src, s_reg.sel.preset_num, s_reg.sel.torque_mode,
                        s_reg.sel.pid_en, s_reg.sel.run_fwd, s_reg.sel.run_rev, s_reg.sel.drive_en,
                        s_reg.dmode, 2'h0};
      end else begin
        s_next.rdata = 32'h0000_0000;
      end
    end
  end

  // State register; every field takes a constant under reset.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg           <= '0;
      s_reg.params    <= {drsel_pkg::PAR_COUNT{drsel_pkg::PARAM_RST}};
      s_reg.sel_param <= drsel_pkg::SEL_PARAM_RST;
      s_reg.dmode     <= drsel_pkg::DM_STATUS;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_mode_held;
    s_reg.tick_d && s_reg.samp.key_mode && s_reg.dmode != drsel_pkg::DM_STATUS
    && s_reg.hold_cnt == drsel_pkg::HOLD_W'(HOLD_TICKS - 1);
  endsequence
  sequence s_idle_out;
    s_reg.tick_d && s_reg.dmode != drsel_pkg::DM_STATUS && !s_reg.samp.key_mode
    && s_reg.idle_cnt == drsel_pkg::IDLE_W'(IDLE_TICKS - 1) && s_reg.samp == s_reg.prev;
  endsequence

  a_volt_analog: assert property (cfg_w == drsel_pkg::CFG_VOLT_PR && !s_reg.samp.analog_input_two
    && !s_reg.samp.digital_input_four |=> sel_out.src == drsel_pkg::SRC_AIN1_VOLT)
    else $error("voltage reference not selected");
  a_curr_preset: assert property (cfg_w == drsel_pkg::CFG_CURR_PR && s_reg.samp.analog_input_two
    |=> sel_out.src == drsel_pkg::SRC_PRESET && sel_out.preset_num >= 4'h3)
    else $error("current config preset wrong");
  a_four_preset: assert property (cfg_w == drsel_pkg::CFG_FOUR_PR |=> sel_out.preset_num ==
    {2'h0, $past(s_reg.samp.analog_input_one), $past(s_reg.samp.digital_input_four)} + 4'h1)
    else $error("four preset decode wrong");
  a_eight_preset: assert property (cfg_w == drsel_pkg::CFG_EIGHT_PR && s_reg.samp.analog_input_two
    && s_reg.samp.analog_input_one && s_reg.samp.digital_input_four |=> sel_out.preset_num == 4'h8)
    else $error("eight preset decode wrong");
  a_torque_mode: assert property (cfg_w == drsel_pkg::CFG_SPEED_TORQUE
    |=> sel_out.torque_mode == $past(s_reg.samp.digital_input_four)
    && (sel_out.src == drsel_pkg::SRC_AIN2) == sel_out.torque_mode)
    else $error("torque selection wrong");
  a_pump_source: assert property (cfg_w == drsel_pkg::CFG_PUMP && s_reg.samp.digital_input_three
    |=> sel_out.src == drsel_pkg::SRC_DIGITAL && !sel_out.run_rev)
    else $error("pump digital reference missing");
  a_pump_pid: assert property (cfg_w == drsel_pkg::CFG_PUMP
    |=> sel_out.pid_en == $past(s_reg.samp.digital_input_four))
    else $error("pump pid mode wrong");
  a_therm_curr: assert property (cfg_w == drsel_pkg::CFG_VOLT_CURR_THERM && s_reg.samp.digital_input_four
    |=> sel_out.src == drsel_pkg::SRC_AIN1_CURR)
    else $error("thermistor config current wrong");
  a_auto_off: assert property (cfg_w == drsel_pkg::CFG_AUTO_MANUAL && !s_reg.samp.sw_auto
    && !s_reg.samp.sw_manual |=> !sel_out.run_fwd && !sel_out.run_rev && sel_out.src == drsel_pkg::SRC_NONE)
    else $error("off position not ignored");
  a_keypad_unlock: assert property (cfg_w == drsel_pkg::CFG_KEYPAD && !s_reg.kp_fwd
    |=> !sel_out.run_fwd)
    else $error("keypad config ran without key");
  a_sign_led: assert property (s_reg.dmode == drsel_pkg::DM_STATUS && s_reg.sel.ref_value[15]
    |=> disp_out.sign_led)
    else $error("sign led dark for negative");
  a_stop_trip: assert property (s_reg.tick_d && s_reg.samp.key_stop && !s_reg.prev.key_stop
    |=> trip_reset ##1 !trip_reset && !s_reg.kp_fwd && !s_reg.kp_rev)
    else $error("stop key not honoured");
  a_hold_exit: assert property (s_mode_held |=> s_reg.dmode == drsel_pkg::DM_STATUS)
    else $error("mode hold did not exit");
  a_idle_exit: assert property (s_idle_out |=> s_reg.dmode == drsel_pkg::DM_STATUS)
    else $error("idle timeout did not exit");
  a_sample_tick: assert property (!tick_w |=> $stable(s_reg.samp))
    else $error("sample changed off tick");

endmodule : drsel_selector

/* File: test/drsel_term_model.sv */
// Terminal wiring and keypad model that presents requested levels to the selector.
// Assumes the bench changes its requests just after rising edges of clk_sys.
`timescale 1ns/10ps
module drsel_term_model (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  drsel_pkg::drsel_pins_s want,
  output drsel_pkg::drsel_pins_s pins
);
  // Run terminals stay open while secure enable is open, like a wired interlock.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pins <= '0;
    end else begin
      // The two run terminals are the top bits of the carrier.
      pins <= {want[13:12] & {2{want.secure_enable_input}}, want[11:0]};
    end
  end
endmodule : drsel_term_model

/* File: test/testbench.sv */
// Self-checking bench of the selector: source decode per configuration and panel modes.
// Assumes the selector package and a single AHB-Lite master, the bench itself.
`timescale 1ns/10ps
module testbench;
  logic                   clk_sys, resetn, hsel, hwrite, hreadyout, hresp, trip_reset;
  logic [1:0]             htrans;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [8:0]             e;
  logic [15:0]            pv [0:28];
  logic [3:0]             cfgs [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8};
  int                     fail_count, total_checks;
  int                     hits;
  logic [15:0]            x;
  logic [6:0]             segtab [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                                          7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  drsel_pkg::drsel_pins_s want, pins;
  drsel_pkg::drsel_sel_s  sel;
  drsel_pkg::drsel_disp_s disp;
  drsel_term_model pm_u (.clk_sys(clk_sys), .resetn(resetn), .want(want), .pins(pins));
  drsel_selector #(.TICK_CYCLES(4), .HOLD_TICKS(5), .IDLE_TICKS(20), .BLINK_TICKS(3)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pins_in(pins), .sel_out(sel), .disp_out(disp), .trip_reset(trip_reset));
  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // One single transfer; the wait is bounded, a hang counts as a mismatch.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin fail_count++; close_out(); end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 200);
    r = hrdata;
    if (hreadyout !== 1'b1) begin fail_count++; close_out(); end
  endtask : ahb
  // Sync flops plus three sampling ticks cover the pin-to-output delay.
  task automatic pins_set(input logic [13:0] b);
    want <= b;
    repeat (14) @(posedge clk_sys);
  endtask : pins_set
  // One key press and release; too short a hold to trip the hold exit.
  task automatic key_tap(input logic [13:0] k);
    pins_set(14'h0100 | k);
    pins_set(14'h0100);
  endtask : key_tap
  // Expected {src, preset, torque, pid} from configuration and v = {ain2, ain1, din4, din3}.
  function automatic logic [8:0] exp_sel(input logic [3:0] c, input logic [3:0] v);
    logic [2:0] s;
    logic [3:0] p;
    s = drsel_pkg::SRC_AIN1_VOLT;
    p = 4'h0;
    if (c < 4'h2 && c == 4'h1) s = drsel_pkg::SRC_AIN1_CURR;
    if (c < 4'h2 && (v[3] | v[1])) begin s = drsel_pkg::SRC_PRESET; p = {2'h0, v[3], v[1]} + 4'h1; end
    if (c == 4'h2) begin s = drsel_pkg::SRC_PRESET; p = {2'h0, v[2], v[1]} + 4'h1; end
    if (c == 4'h3) begin s = drsel_pkg::SRC_PRESET; p = {1'h0, v[3:1]} + 4'h1; end
    if (c == 4'h5 && v[1]) s = drsel_pkg::SRC_AIN2;
    if (c == 4'h7 && v[0]) s = drsel_pkg::SRC_DIGITAL;
    if (c == 4'h8 && v[1]) s = drsel_pkg::SRC_AIN1_CURR;
    return {s, p, c == 4'h5 && v[1], c == 4'h7 && v[1]};
  endfunction : exp_sel
  // Expected four hex digits of the magnitude, leftmost digit first.
  function automatic logic [27:0] exp_seg(input logic [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'h0000 - v : v;
    return {segtab[m[15:12]], segtab[m[11:8]], segtab[m[7:4]], segtab[m[3:0]]};
  endfunction : exp_seg
  // Main sequence: reset, parameter fill, decode sweep, run and panel modes.
  initial begin
    void'($urandom(32'h4d22));
    {resetn, hsel, hwrite, htrans, haddr, hwdata, want, fail_count, total_checks} = '0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(sel.src, drsel_pkg::SRC_AIN1_VOLT);
    pv[2] = 16'($urandom);
    ahb(1'b1, 32'h0000_0004, {16'h0000, pv[2]}, rd);
    for (int i = 18; i < 29; i++) begin pv[i] = 16'($urandom); ahb(1'b1, 4 * (i - 1), pv[i], rd); end
    ahb(1'b0, 32'h0000_0044, 32'h0, rd);
    chk(rd, {16'h0000, pv[18]});
    ahb(1'b0, 32'h0000_0300, 32'h0, rd);
    chk(rd, 32'h0);
    foreach (cfgs[k]) begin
      pins_set(14'h0000);
      ahb(1'b1, 32'h0000_0010, cfgs[k], rd);
      for (int v = 0; v < 16; v++) begin
        pins_set({1'b0, v[0], v[1], v[2], v[3], 9'h100});
        e = exp_sel(cfgs[k], v[3:0]);
        chk({sel.src, sel.preset_num}, e[8:2]);
        chk({sel.torque_mode, sel.pid_en}, e[1:0]);
        chk(sel.ref_value, e[8:6] == 3'h4 ? pv[20 + e[5:2]] : e[8:6] == 3'h5 ? pv[18] : 16'h0);
        chk(sel.speed_limit, pv[2]);
      end
    end
    pins_set(14'h2100);
    chk({sel.run_fwd, sel.drive_en}, 2'h3);
    pins_set(14'h0120);
    chk(disp.param_mode, 1'b1);
    repeat (30) @(posedge clk_sys);
    chk(disp.param_mode, 1'b0);
    pins_set(14'h0100);
    pins_set(14'h0120);
    pins_set(14'h0100);
    chk(disp.param_mode, 1'b1);
    repeat (90) @(posedge clk_sys);
    chk(disp.param_mode, 1'b0);
    // Keypad configuration: terminals never run, keys latch a direction, stop clears it.
    pins_set(14'h0000);
    ahb(1'b1, 32'h0000_0010, 32'h0000_000A, rd);
    pins_set(14'h2100);
    chk({sel.src, sel.run_fwd, sel.run_rev, sel.drive_en}, {drsel_pkg::SRC_KEYPAD, 3'h1});
    chk(sel.ref_value, pv[20]);
    pins_set(14'h0101);
    chk({sel.run_fwd, sel.run_rev}, 2'h2);
    pins_set(14'h0104);
    chk({sel.run_fwd, sel.run_rev}, 2'h1);
    want <= 14'h0102;
    hits = 0;
    repeat (14) begin
      @(posedge clk_sys);
      hits += trip_reset;
    end
    chk(hits, 1);
    chk({sel.run_fwd, sel.run_rev}, 2'h0);
    // Auto-manual configuration through off, auto and manual positions.
    pins_set(14'h0000);
    ahb(1'b1, 32'h0000_0010, 32'h0000_000B, rd);
    pins_set(14'h2100);
    chk({sel.src, sel.run_fwd}, {drsel_pkg::SRC_NONE, 1'b0});
    pins_set(14'h2180);
    chk({sel.src, sel.run_fwd}, {drsel_pkg::SRC_AIN1_VOLT, 1'b1});
    pins_set(14'h2140);
    chk({sel.src, sel.run_fwd}, {drsel_pkg::SRC_KEYPAD, 1'b0});
    ahb(1'b0, 32'h0000_0200, 32'h0, rd);
    chk(rd, 32'h0000_C010);
    chk(hresp, 1'b0);
    chk(disp.seg, exp_seg(pv[20]));
    chk(disp.sign_led, pv[20][15]);
    // Panel: select parameter 02, raise it by one in edit, read it back over the bus.
    key_tap(14'h0020);
    key_tap(14'h0010);
    key_tap(14'h0020);
    key_tap(14'h0010);
    x = pv[2] + 16'h0001;
    chk(disp.seg, exp_seg(x));
    chk(disp.sign_led, x[15]);
    key_tap(14'h0020);
    ahb(1'b0, 32'h0000_0004, 32'h0, rd);
    chk(rd, {16'h0000, x});
    close_out();
  end
endmodule : testbench
